// >>> battery_monitor_config_regs.sv
//
// Contract
// RULE1: Acquisition time from two-bit field, reset 00
// RULE2: Host uses termination only with longest acquisition
// RULE3: Lock high captures address for CRC
// RULE4: Lock low: CRC uses address zero
// RULE5: Increment bit adds one when forwarding address
// RULE6: Readback bit enables chain register readback
// RULE7: Alert when cell result above high limit
// RULE8: Alert when cell result below low limit
// RULE9: Alert when auxiliary result above high limit
// RULE10: Alert when auxiliary result below low limit
// RULE11: Static alert idles high, low on fault
// RULE12: Dynamic alert square wave at chosen rate
// RULE13: Host sets mode only on top device
// RULE14: Pass incoming alert, or force low on fault
// RULE15: Balance bits 7..2 drive six outputs
// RULE16: Balance cleared at reset, soft reset, wake
// RULE17: Per-output five-bit timer, 71.5 s steps
// RULE18: Zero timer code leaves output manual
// RULE19: Auto power-down after five-bit step count
// RULE20: Power-down timer overrides balance timers
// RULE21: Soft reset defaults all except control low
// RULE22: Expired timer clears output; zero disables sleep
// RULE23: Tick and alert rates from fixed prescalers
//
`timescale 1ns/100ps
module battery_monitor_config_regs
	import monitor_cfg_pkg::*;
#(
	parameter int TICK_CYC   = TICK_CYCLES,    // Cycles per 1 ms prescaler tick
	parameter int STEP_TICKS = STEP_TIME_MS,   // Prescaler ticks per 71.5 s step
	parameter int HALF_SLOW  = HALF_SLOW_CYC,  // Half period of slow square wave
	parameter int HALF_MID   = HALF_MID_CYC,   // Half period of middle square wave
	parameter int HALF_FAST  = HALF_FAST_CYC   // Half period of fast square wave
)(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       sclk,              // Serial clock pin, idles low
	input  wire logic       cs_b,              // Frame select pin
	input  wire logic       sdi,               // Serial data in pin
	input  wire logic       alert_in,          // Alert from the device above
	input  wire logic       power_down_pin_b,  // Hardware power-down pin
	input  wire logic       soft_reset,        // Software reset level, same clock
	input  wire logic       result_valid,      // A conversion result is present
	input  wire logic       result_is_aux,     // Result belongs to an auxiliary input
	input  wire logic [7:0] result_level,      // Result scaled to the limit code
	output logic            alert_out,         // Alert toward the device below
	output logic [5:0]      balance_output,    // Cell balance drives, bit 5 is output six
	output logic [1:0]      acquisition_time,  // Converter acquisition select
	output logic            thermistor_termination_pin,
	output logic            chain_readback_enable,
	output logic [4:0]      crc_device_address,
	output logic [4:0]      forward_device_address,
	output logic            forward_valid,     // Pulse with each accepted frame
	output logic            power_down
);

	// ==========================================================
	// Helpers
	// ==========================================================
	// Out-of-window test shared by cell and auxiliary results
	function automatic logic out_of_window(input logic [7:0] level,
	                                       input logic [7:0] high,
	                                       input logic [7:0] low);
		out_of_window = (level > high) || (level < low);
	endfunction : out_of_window

	// Decode a frame into a command; the address travels LSB first
	function automatic write_cmd_t decode(input logic [31:0] frame);
		write_cmd_t c;
		c.dev_addr = {frame[27], frame[28], frame[29], frame[30], frame[31]};
		c.reg_addr = frame[26:21];
		c.data     = frame[20:13];
		c.all      = frame[12];
		decode     = c;
	endfunction : decode

	// ==========================================================
	// State
	// ==========================================================
	core_state_t s_r;                 // Registered state
	core_state_t s_nxt;               // Next state
	logic [5:0]  bal_expired;         // Balance timer expiry pulses
	logic        sleep_expired;       // Power-down timer expiry pulse
	logic        sleep_running;       // Power-down timer counting
	logic [5:0]  bal_running;         // Balance timers counting

	// Balance timers; stop while software reset or powered down (sleep timer or pin)
	for (genvar g = 0; g < NUM_BALANCE; g++) begin : g_bal_tmr
		step_timer u_tmr (
			.clk     (clk),
			.rst_b   (rst_b),
			.load    (s_r.load[g]),
			.code    (s_r.bal_tmr[g]),
			.tick    (s_r.step_tick),                  // [RULE17]
			.stop    (soft_reset || s_r.power_down),   // [RULE20]
			.expired (bal_expired[g]),
			.running (bal_running[g])
		);
	end

	// Power-down timer
	step_timer u_sleep_tmr (
		.clk     (clk),
		.rst_b   (rst_b),
		.load    (s_r.load[NUM_BALANCE]),
		.code    (s_r.sleep_tmr),                      // [RULE19]
		.tick    (s_r.step_tick),
		.stop    (soft_reset || s_r.power_down),
		.expired (sleep_expired),
		.running (sleep_running)
	);

	// ==========================================================
	// Next-state logic
	// ==========================================================
	always_comb begin
		write_cmd_t  cmd;
		logic        frame_ok;
		logic        hit;
		logic [4:0]  own_addr;
		logic [19:0] half_lim;
		alert_mode_t mode;
		logic        fault;

		s_nxt       = s_r;
		cmd         = decode(s_r.shift);
		frame_ok    = 1'b0;
		hit         = 1'b0;
		own_addr    = 5'h00;
		half_lim    = 20'h00000;
		mode        = alert_mode_t'(s_r.alert_cfg[1:0]);
		fault       = 1'b0;
		s_nxt.load      = 7'h00;
		s_nxt.fwd_valid = 1'b0;
		s_nxt.step_tick = 1'b0;

		// Two-stage synchronisers; only stage [1] is read below
		s_nxt.sclk_s  = {s_r.sclk_s[0], sclk};
		s_nxt.cs_s    = {s_r.cs_s[0], cs_b};
		s_nxt.sdi_s   = {s_r.sdi_s[0], sdi};
		s_nxt.alert_s = {s_r.alert_s[0], alert_in};
		s_nxt.pdpin_s = {s_r.pdpin_s[0], power_down_pin_b};
		s_nxt.sclk_prev  = s_r.sclk_s[1];
		s_nxt.cs_prev    = s_r.cs_s[1];
		s_nxt.pdpin_prev = s_r.pdpin_s[1];

		// Serial receive: shift on falling SCLK while the frame is open
		if (s_r.cs_s[1]) begin
			// Counter cleared while deselected so every frame resynchronises
			s_nxt.bits = 6'h00;
		end else if (s_r.sclk_prev && !s_r.sclk_s[1]) begin
			s_nxt.shift = {s_r.shift[30:0], s_r.sdi_s[1]};
			if (s_r.bits != 6'h3F) begin
				s_nxt.bits = s_r.bits + 6'h01;
			end
		end

		// Frame closes on the rising edge of the select
		if (!s_r.cs_prev && s_r.cs_s[1]) begin
			// Only a full frame with the fixed tail pattern is executed
			frame_ok = (s_r.bits == 6'(FRAME_BITS)) && (s_r.shift[2:0] == FRAME_PATTERN);
		end

		// Address this device answers to
		own_addr = s_r.locked ? s_r.dev_addr : 5'h00;            // [RULE3] [RULE4]
		hit      = frame_ok && (cmd.all || cmd.dev_addr == own_addr);

		// Every good frame moves up the chain, address bumped if asked
		if (frame_ok) begin
			s_nxt.fwd_valid = 1'b1;
			if (s_r.ctrl_low[CTRL_INC_BIT]) begin
				s_nxt.fwd_addr = cmd.dev_addr + 5'h01;          // [RULE5]
			end else begin
				s_nxt.fwd_addr = cmd.dev_addr;                  // [RULE5]
			end
		end

		// Register writes
		if (hit) begin
			case (cmd.reg_addr)
				REG_CTRL_LOW: begin
					s_nxt.ctrl_low = cmd.data;                   // [RULE1] [RULE6]
					// Lock takes the address presented in this very command
					if (cmd.data[CTRL_LOCK_BIT]) begin
						s_nxt.locked   = 1'b1;                   // [RULE3]
						s_nxt.dev_addr = cmd.dev_addr;           // [RULE3]
					end else begin
						s_nxt.locked   = 1'b0;                   // [RULE4]
						s_nxt.dev_addr = 5'h00;                  // [RULE4]
					end
				end
				REG_CELL_HIGH: s_nxt.cell_hi   = cmd.data;      // [RULE7]
				REG_CELL_LOW:  s_nxt.cell_lo   = cmd.data;      // [RULE8]
				REG_AUX_HIGH:  s_nxt.aux_hi    = cmd.data;      // [RULE9]
				REG_AUX_LOW:   s_nxt.aux_lo    = cmd.data;      // [RULE10]
				REG_ALERT_CFG: s_nxt.alert_cfg = cmd.data;
				REG_BALANCE:   s_nxt.balance   = cmd.data[7:BAL_LSB]; // [RULE15]
				REG_SLEEP_TMR: begin
					s_nxt.sleep_tmr            = cmd.data[7:TMR_LSB];  // [RULE19]
					s_nxt.load[NUM_BALANCE]    = 1'b1;
				end
				default: begin
					// Balance timer block; other addresses are ignored here
					for (int i = 0; i < NUM_BALANCE; i++) begin
						if (cmd.reg_addr == REG_BAL_TMR_BASE + 6'(i)) begin
							s_nxt.bal_tmr[i] = cmd.data[7:TMR_LSB];   // [RULE17]
							s_nxt.load[i]    = 1'b1;
						end
					end
				end
			endcase
		end

		// Expired balance timer switches its output off
		for (int i = 0; i < NUM_BALANCE; i++) begin
			if (bal_expired[i]) begin
				s_nxt.balance[i] = 1'b0;                        // [RULE22]
			end
		end

		// Power-down: timer expiry or the hardware pin
		if (sleep_expired) begin
			s_nxt.asleep = 1'b1;                                // [RULE19]
		end
		s_nxt.power_down = s_nxt.asleep || !s_r.pdpin_s[1];

		// Leaving hardware power-down clears balance and wakes the part
		if (!s_r.pdpin_prev && s_r.pdpin_s[1]) begin
			s_nxt.asleep  = 1'b0;
			s_nxt.balance = BALANCE_RESET;                      // [RULE16]
		end

		// Software reset: defaults everywhere except the control low byte
		if (soft_reset) begin
			s_nxt.cell_hi   = HIGH_LIMIT_RESET;                 // [RULE21]
			s_nxt.cell_lo   = LOW_LIMIT_RESET;
			s_nxt.aux_hi    = HIGH_LIMIT_RESET;
			s_nxt.aux_lo    = LOW_LIMIT_RESET;
			s_nxt.alert_cfg = ALERT_RESET;
			s_nxt.balance   = BALANCE_RESET;                    // [RULE16]
			s_nxt.bal_tmr   = '0;
			s_nxt.sleep_tmr = TIMER_RESET;
			s_nxt.asleep    = 1'b0;
		end

		// Outputs follow the register, forced off while powered down
		s_nxt.bal_out = s_r.power_down ? 6'h00 : s_r.balance;   // [RULE15] [RULE18] [RULE20]
		s_nxt.crc_addr = own_addr;                              // [RULE3] [RULE4]

		// Limit checks, refreshed by each result of the matching kind
		if (result_valid) begin
			if (result_is_aux) begin
				s_nxt.aux_fault  = out_of_window(result_level, s_r.aux_hi, s_r.aux_lo);   // [RULE9] [RULE10]
			end else begin
				s_nxt.cell_fault = out_of_window(result_level, s_r.cell_hi, s_r.cell_lo); // [RULE7] [RULE8]
			end
		end
		fault = s_r.cell_fault || s_r.aux_fault;

		// Prescaler chain: 1 ms base, then 71.5 s steps; a 71.5 s count
		// at 200 MHz would not fit 32 bits, hence the two stages
		if (s_r.ms_cnt == 18'(TICK_CYC - 1)) begin
			s_nxt.ms_cnt = 18'h00000;
			if (s_r.step_cnt == 17'(STEP_TICKS - 1)) begin
				s_nxt.step_cnt  = 17'h00000;
				s_nxt.step_tick = 1'b1;                         // [RULE23]
			end else begin
				s_nxt.step_cnt = s_r.step_cnt + 17'h00001;
			end
		end else begin
			s_nxt.ms_cnt = s_r.ms_cnt + 18'h00001;
		end

		// Square-wave divider for the dynamic alert
		case (alert_rate_t'(s_r.alert_cfg[ALERT_FREQ_LSB +: 2]))
			RATE_MID:  half_lim = 20'(HALF_MID - 1);
			RATE_FAST: half_lim = 20'(HALF_FAST - 1);
			default:   half_lim = 20'(HALF_SLOW - 1);
		endcase
		if (s_r.half_cnt >= half_lim) begin
			s_nxt.half_cnt = 20'h00000;
			s_nxt.square   = !s_r.square;                       // [RULE12] [RULE23]
		end else begin
			s_nxt.half_cnt = s_r.half_cnt + 20'h00001;
		end

		// Alert output; any local fault pulls the line low in every mode
		case (mode)
			ALERT_STATIC:  s_nxt.alert_out = !fault;                    // [RULE11]
			ALERT_DYNAMIC: s_nxt.alert_out = !fault && s_r.square;      // [RULE12]
			ALERT_PASS:    s_nxt.alert_out = !fault && s_r.alert_s[1];  // [RULE14]
			default:       s_nxt.alert_out = !fault;
		endcase
	end

	// ==========================================================
	// State register
	// ==========================================================
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_r           <= '0;
			s_r.sclk_s    <= 2'h0;
			s_r.cs_s      <= 2'h3;
			s_r.cs_prev   <= 1'b1;
			s_r.pdpin_s   <= 2'h3;
			s_r.pdpin_prev<= 1'b1;
			s_r.alert_s   <= 2'h3;
			s_r.ctrl_low  <= CTRL_LOW_RESET;                    // [RULE1] [RULE5] [RULE6]
			s_r.cell_hi   <= HIGH_LIMIT_RESET;
			s_r.cell_lo   <= LOW_LIMIT_RESET;
			s_r.aux_hi    <= HIGH_LIMIT_RESET;
			s_r.aux_lo    <= LOW_LIMIT_RESET;
			s_r.alert_cfg <= ALERT_RESET;
			s_r.balance   <= BALANCE_RESET;                     // [RULE16]
			s_r.alert_out <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Outputs, all straight from the state register
	// ==========================================================
	assign alert_out                  = s_r.alert_out;
	assign balance_output             = s_r.bal_out;
	assign acquisition_time           = s_r.ctrl_low[CTRL_ACQ_LSB +: 2];  // [RULE1]
	// The host keeps this off unless acquisition is at its longest
	assign thermistor_termination_pin = s_r.ctrl_low[CTRL_TERM_BIT];
	assign chain_readback_enable      = s_r.ctrl_low[CTRL_READBACK_BIT]; // [RULE6]
	assign crc_device_address         = s_r.crc_addr;
	assign forward_device_address     = s_r.fwd_addr;
	assign forward_valid              = s_r.fwd_valid;
	assign power_down                 = s_r.power_down;

endmodule : battery_monitor_config_regs

// >>> battery_monitor_config_regs_assertions.sv
`timescale 1ns/100ps
// ==========================================================
// Port checker
// ==========================================================
module monitor_cfg_checker (
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic       cs_b,
	input wire logic       soft_reset,
	input wire logic       power_down_pin_b,
	input wire logic       forward_valid,
	input wire logic [4:0] forward_device_address,
	input wire logic [4:0] crc_device_address,
	input wire logic [1:0] acquisition_time,
	input wire logic       thermistor_termination_pin,
	input wire logic       chain_readback_enable,
	input wire logic [5:0] balance_output,
	input wire logic       alert_out,
	input wire logic       power_down
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	chk_reset_values: assert property (
		$rose(rst_b) |-> alert_out && chain_readback_enable && !thermistor_termination_pin
		&& acquisition_time == 2'b00 && crc_device_address == 5'h00 && balance_output == 6'h00)
		else $error("outputs not at reset values");
	chk_pulse_single: assert property (
		forward_valid |=> !forward_valid) else $error("forward pulse too long");
	chk_pulse_after_frame: assert property (
		$rose(forward_valid) |-> cs_b && $past(cs_b, 2)) else $error("forward pulse inside frame");
	chk_forward_hold: assert property (
		!forward_valid && !$past(soft_reset) |-> $stable(forward_device_address))
		else $error("forward address moved without frame");
	chk_crc_cause: assert property (
		$changed(crc_device_address) |-> $past(forward_valid) || $past(forward_valid, 2))
		else $error("crc address moved without frame");
	chk_ctrl_cause: assert property (
		$changed({acquisition_time, thermistor_termination_pin, chain_readback_enable})
		|-> forward_valid) else $error("control moved alone");
	chk_soft_keeps_ctrl: assert property (
		soft_reset |=> $stable({acquisition_time, chain_readback_enable, crc_device_address}))
		else $error("soft reset touched control");
	chk_soft_clears_balance: assert property (
		soft_reset ##1 soft_reset |=> balance_output == 6'h00) else $error("balance kept");
	chk_sleep_blanks: assert property (
		power_down && $past(power_down) |-> balance_output == 6'h00) else $error("balance on asleep");
	chk_wake_clears: assert property (
		$rose(power_down_pin_b) |-> ##8 (!power_down && balance_output == 6'h00))
		else $error("wake did not clear balance");
endmodule : monitor_cfg_checker

bind battery_monitor_config_regs monitor_cfg_checker i_monitor_cfg_checker (.clk, .rst_b,
	.cs_b, .soft_reset, .power_down_pin_b, .forward_valid, .forward_device_address,
	.crc_device_address, .acquisition_time, .thermistor_termination_pin,
	.chain_readback_enable, .balance_output, .alert_out, .power_down);

// >>> host_link_model.sv
`timescale 1ns/100ps
// ==========================================================
// Host end of the serial link
// ==========================================================
module host_link_model (
	output logic sclk,
	output logic cs_b,
	output logic sdi
);
	// Link clock stands still low between frames
	initial begin
		sclk = 1'b0;
		cs_b = 1'b1;
		sdi  = 1'b0;
	end

	// Frame sent MSB first, 125 ns bit period; short count tests refusal
	task automatic send(input logic [31:0] frame, input int nb);
		cs_b = 1'b0;
		#100;
		for (int i = 31; i > 31 - nb; i--) begin
			sclk = 1'b1;
			sdi  = frame[i];   // Set on the rise, device samples on the fall
			#62.5;
			sclk = 1'b0;
			#62.5;
		end
		cs_b = 1'b1;
		sdi  = ~sdi;           // Released line must not keep the last bit
	endtask : send
endmodule : host_link_model

// >>> monitor_cfg_pkg.sv
package monitor_cfg_pkg;

	// ==========================================================
	// Clock and time bases
	// ==========================================================
	localparam int CLK_HZ          = 200_000_000;   // System clock rate
	localparam int TICK_TIME_MS    = 1;             // Base prescaler period, ms
	localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_TIME_MS;
	localparam int STEP_TIME_MS    = 71_500;        // One timer step, 71.5 s
	localparam int ALERT_SLOW_HZ   = 100;           // Dynamic alert rates
	localparam int ALERT_MID_HZ    = 1_000;
	localparam int ALERT_FAST_HZ   = 10_000;
	localparam int HALF_SLOW_CYC   = CLK_HZ / (2 * ALERT_SLOW_HZ);
	localparam int HALF_MID_CYC    = CLK_HZ / (2 * ALERT_MID_HZ);
	localparam int HALF_FAST_CYC   = CLK_HZ / (2 * ALERT_FAST_HZ);

	// ==========================================================
	// Register addresses (6-bit register field of a write frame)
	// ==========================================================
	localparam logic [5:0] REG_CTRL_LOW     = 6'h0E;
	localparam logic [5:0] REG_CELL_HIGH    = 6'h0F;
	localparam logic [5:0] REG_CELL_LOW     = 6'h10;
	localparam logic [5:0] REG_AUX_HIGH     = 6'h11;
	localparam logic [5:0] REG_AUX_LOW      = 6'h12;
	localparam logic [5:0] REG_ALERT_CFG    = 6'h13;
	localparam logic [5:0] REG_BALANCE      = 6'h14;
	localparam logic [5:0] REG_BAL_TMR_BASE = 6'h15;   // Six timers, 0x15..0x1A
	localparam logic [5:0] REG_SLEEP_TMR    = 6'h1B;

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic [7:0] CTRL_LOW_RESET   = 8'h13;   // Readback, increment, bit4 set
	localparam logic [7:0] HIGH_LIMIT_RESET = 8'hFF;
	localparam logic [7:0] LOW_LIMIT_RESET  = 8'h00;
	localparam logic [7:0] ALERT_RESET      = 8'h00;
	localparam logic [5:0] BALANCE_RESET    = 6'h00;
	localparam logic [4:0] TIMER_RESET      = 5'h00;

	// ==========================================================
	// Field positions
	// ==========================================================
	localparam int CTRL_READBACK_BIT = 0;
	localparam int CTRL_INC_BIT      = 1;
	localparam int CTRL_LOCK_BIT     = 2;
	localparam int CTRL_TERM_BIT     = 3;
	localparam int CTRL_ACQ_LSB      = 5;
	localparam int BAL_LSB           = 2;       // Balance bits live in [7:2]
	localparam int TMR_LSB           = 3;       // Timer code lives in [7:3]
	localparam int ALERT_FREQ_LSB    = 2;       // Alert rate select in [3:2]
	localparam int FRAME_BITS        = 32;
	localparam logic [2:0] FRAME_PATTERN = 3'h2;
	localparam int NUM_BALANCE       = 6;

	// ==========================================================
	// Enumerations
	// ==========================================================
	typedef enum logic [1:0] {ALERT_PASS, ALERT_STATIC, ALERT_DYNAMIC, ALERT_RSVD} alert_mode_t;
	typedef enum logic [1:0] {RATE_SLOW, RATE_MID, RATE_FAST, RATE_RSVD} alert_rate_t;

	// ==========================================================
	// Carriers
	// ==========================================================
	typedef struct packed {
		logic [4:0] dev_addr;   // Device address, already bit-reversed
		logic [5:0] reg_addr;   // Target register
		logic [7:0] data;       // Data byte
		logic       all;        // Write to every device in the chain
	} write_cmd_t;

	typedef struct packed {
		logic [4:0] remain;     // Steps left
		logic       running;    // Counting
		logic       expired;    // One-cycle expiry pulse
	} step_timer_state_t;

	typedef struct packed {
		logic [1:0]            sclk_s, cs_s, sdi_s, alert_s, pdpin_s; // [0] first stage
		logic                  sclk_prev, cs_prev, pdpin_prev;
		logic [31:0]           shift;
		logic [5:0]            bits;
		logic [7:0]            ctrl_low, cell_hi, cell_lo, aux_hi, aux_lo, alert_cfg;
		logic [5:0]            balance;
		logic [5:0][4:0]       bal_tmr;
		logic [4:0]            sleep_tmr;
		logic                  locked;
		logic [4:0]            dev_addr, crc_addr, fwd_addr;
		logic                  fwd_valid;
		logic                  cell_fault, aux_fault;
		logic                  alert_out, square;
		logic [19:0]           half_cnt;
		logic [17:0]           ms_cnt;
		logic [16:0]           step_cnt;
		logic                  step_tick;
		logic                  asleep, power_down;
		logic [6:0]            load;      // [5:0] balance timers, [6] sleep timer
		logic [5:0]            bal_out;
	} core_state_t;

endpackage : monitor_cfg_pkg

// >>> step_timer.sv
`timescale 1ns/100ps
module step_timer
	import monitor_cfg_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       load,      // Restart with a new code
	input  wire logic [4:0] code,      // Steps to run, zero keeps it idle
	input  wire logic       tick,      // One pulse per step
	input  wire logic       stop,      // Abandon the count
	output logic            expired,   // One cycle at the end of the last step
	output logic            running
);

	// ==========================================================
	// State
	// ==========================================================
	step_timer_state_t st_r;   // Registered state
	step_timer_state_t st_nxt; // Next state

	// Down-counter; a zero code never starts, so the output stays manual
	always_comb begin
		st_nxt         = st_r;
		st_nxt.expired = 1'b0;
		if (stop) begin
			st_nxt.running = 1'b0;
		end else if (load) begin
			st_nxt.remain  = code;
			st_nxt.running = (code != 5'h00);
		end else if (tick && st_r.running) begin
			// Last step ends the run
			st_nxt.remain = st_r.remain - 5'h01;
			if (st_r.remain == 5'h01) begin
				st_nxt.running = 1'b0;
				st_nxt.expired = 1'b1;
			end
		end
	end

	// Register the state
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign expired = st_r.expired;
	assign running = st_r.running;

endmodule : step_timer

// >>> testbench.sv
`timescale 1ns/100ps
// ==========================================================
// Bench top
// ==========================================================
module testbench;
	import monitor_cfg_pkg::*;
	logic       clk, rst_b, sclk, cs_b, sdi, alert_in, power_down_pin_b, soft_reset;
	logic       result_valid, result_is_aux, alert_out, thermistor_termination_pin;
	logic       chain_readback_enable, forward_valid, power_down;
	logic [7:0] result_level;
	logic [5:0] balance_output;
	logic [4:0] crc_device_address, forward_device_address;
	logic [1:0] acquisition_time;
	int         error_cnt, checked, n;

	// Short prescalers: one timer step is 12 cycles
	battery_monitor_config_regs #(.TICK_CYC(4), .STEP_TICKS(3), .HALF_SLOW(8), .HALF_MID(4),
		.HALF_FAST(2)) i_battery_monitor_config_regs (.clk, .rst_b, .sclk, .cs_b, .sdi,
		.alert_in, .power_down_pin_b, .soft_reset, .result_valid, .result_is_aux,
		.result_level, .alert_out, .balance_output, .acquisition_time,
		.thermistor_termination_pin, .chain_readback_enable, .crc_device_address,
		.forward_device_address, .forward_valid, .power_down);
	host_link_model i_host_link_model (.sclk, .cs_b, .sdi);

	always #2.5 clk = ~clk;

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	// Write frame, then judge whether the forward pulse came
	task automatic wr(input logic [5:0] r, input logic [7:0] d, input logic [4:0] a = 5'h00,
		input logic all = 1'b1, input int nb = 32, input logic ok = 1'b1);
		logic seen = 1'b0;
		i_host_link_model.send({a[0], a[1], a[2], a[3], a[4], r, d, all, 9'h000, FRAME_PATTERN}, nb);
		repeat (20) begin
			@(negedge clk);
			seen |= forward_valid;
		end
		cmp({7'h00, seen}, {7'h00, ok});
	endtask : wr

	// One result pulse, alert judged two stages later
	task automatic res(input logic aux, input logic [7:0] lvl, input logic exp);
		@(posedge clk);
		result_valid  <= 1'b1;
		result_is_aux <= aux;
		result_level  <= lvl;
		@(posedge clk);
		result_valid <= 1'b0;
		repeat (4) @(negedge clk);
		cmp({7'h00, alert_out}, {7'h00, exp});
	endtask : res

	task automatic t_ctrl();
		wr(REG_CTRL_LOW, 8'h7F, 5'h05);
		cmp({3'h0, crc_device_address}, 8'h05);
		cmp({3'h0, forward_device_address}, 8'h06);
		cmp({5'h00, acquisition_time, thermistor_termination_pin}, 8'h07);
		wr(REG_CTRL_LOW, 8'h10, 5'h05, 1'b0);
		cmp({2'h0, crc_device_address, chain_readback_enable}, 8'h00);
		wr(REG_CTRL_LOW, 8'h13, 5'h09, 1'b0);
		cmp({3'h0, forward_device_address}, 8'h09);
		wr(REG_CTRL_LOW, 8'h13, 5'h00, 1'b1, 31, 1'b0);
		cmp({7'h00, chain_readback_enable}, 8'h00);
		wr(REG_CTRL_LOW, 8'h13);
		cmp({7'h00, chain_readback_enable}, 8'h01);
	endtask : t_ctrl

	task automatic t_alert();
		logic [9:0] tbl [10] = '{10'h101, 10'h102, 10'h081, 10'h07E, 10'h081,
			10'h321, 10'h322, 10'h241, 10'h23E, 10'h241};
		int         tog;
		logic       prev;
		wr(REG_CELL_HIGH, 8'h80);
		wr(REG_CELL_LOW, 8'h40);
		wr(REG_AUX_HIGH, 8'h90);
		wr(REG_AUX_LOW, 8'h20);
		wr(REG_ALERT_CFG, 8'h01);
		foreach (tbl[i]) res(tbl[i][9], tbl[i][8:1], tbl[i][0]);
		for (int k = 0; k < 3; k++) begin
			wr(REG_ALERT_CFG, {4'h0, k[1:0], 2'h2});
			tog  = 0;
			prev = alert_out;
			repeat (48) begin
				@(negedge clk);
				tog += int'(alert_out !== prev);
				prev = alert_out;
			end
			cmp({7'h00, tog inside {[(6 << k) - 1 : (6 << k) + 1]}}, 8'h01);
		end
		res(1'b0, 8'h81, 1'b0);
		wr(REG_ALERT_CFG, 8'h00);
		res(1'b0, 8'h40, 1'b1);
		@(posedge clk) alert_in <= 1'b0;
		repeat (5) @(negedge clk);
		cmp({7'h00, alert_out}, 8'h00);
		@(posedge clk) alert_in <= 1'b1;
		res(1'b1, 8'h91, 1'b0);
		res(1'b1, 8'h20, 1'b1);
	endtask : t_alert

	task automatic t_bal();
		wr(REG_BALANCE, 8'hFC);
		cmp({2'h0, balance_output}, 8'h3F);
		wr(REG_BALANCE, 8'h87);
		cmp({2'h0, balance_output}, 8'h21);
		wr(REG_BAL_TMR_BASE + 6'h05, 8'h00);
		wr(REG_BAL_TMR_BASE, 8'h08);
		for (n = 0; n < 40 && balance_output[0] !== 1'b0; n++) @(negedge clk);
		if (n == 40) begin
			error_cnt++;
			results();
		end
		cmp({2'h0, balance_output}, 8'h20);
		wr(REG_SLEEP_TMR, 8'h00);
		repeat (60) @(negedge clk);
		cmp({7'h00, power_down}, 8'h00);
		wr(REG_SLEEP_TMR, 8'h10);
		for (n = 0; n < 60 && power_down !== 1'b1; n++) @(negedge clk);
		if (n == 60) begin
			error_cnt++;
			results();
		end
		@(negedge clk);
		cmp({1'b0, power_down, balance_output}, 8'h40);
		@(posedge clk) power_down_pin_b <= 1'b0;
		repeat (10) @(negedge clk);
		@(posedge clk) power_down_pin_b <= 1'b1;
		repeat (10) @(negedge clk);
		cmp({1'b0, power_down, balance_output}, 8'h00);
	endtask : t_bal

	task automatic t_soft();
		wr(REG_CTRL_LOW, 8'h53);
		wr(REG_CELL_HIGH, 8'h10);
		wr(REG_BALANCE, 8'hFC);
		@(posedge clk) soft_reset <= 1'b1;
		repeat (2) @(posedge clk);
		soft_reset <= 1'b0;
		repeat (3) @(negedge clk);
		cmp({acquisition_time, balance_output}, 8'h80);
		wr(REG_ALERT_CFG, 8'h01);
		res(1'b0, 8'h80, 1'b1);
	endtask : t_soft

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results

	initial begin
		clk              = 1'b0;
		rst_b            = 1'b0;
		alert_in         = 1'b1;
		power_down_pin_b = 1'b1;
		soft_reset       = 1'b0;
		result_valid     = 1'b0;
		result_is_aux    = 1'b0;
		result_level     = 8'h00;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		cmp({alert_out, chain_readback_enable, thermistor_termination_pin, power_down,
			forward_valid, acquisition_time, 1'b0}, 8'hC0);
		cmp({balance_output, 2'h0}, 8'h00);
		cmp({crc_device_address, forward_device_address[2:0]}, 8'h00);
		t_ctrl();
		t_alert();
		t_bal();
		t_soft();
		results();
	end
endmodule : testbench
